// >>> pct_pkg.sv
package pct_pkg;
    // staging width for one descriptor plus one payload dword
    localparam int HDR_W = 256;
    localparam int REGION_AW = 9;
    localparam int MEM_WORDS = 2048;
    localparam int FIFO_DEPTH = 16;

    // completer request descriptor layout
    localparam int CQ_AT_LSB = 0;
    localparam int CQ_ADDR_LSB = 2;
    localparam int CQ_DWC_LSB = 64;
    localparam int CQ_TYPE_LSB = 75;
    localparam int CQ_RID_LSB = 80;
    localparam int CQ_TAG_LSB = 96;
    localparam int CQ_WIN_LSB = 112;
    localparam int CQ_TC_LSB = 121;
    localparam int CQ_ATTR_LSB = 124;
    localparam int CQ_DATA_LSB = 128;

    // completion descriptor layout
    localparam int CC_LA_LSB = 0;
    localparam int CC_AT_LSB = 8;
    localparam int CC_BC_LSB = 16;
    localparam int CC_DWC_LSB = 32;
    localparam int CC_ST_LSB = 43;
    localparam int CC_RID_LSB = 48;
    localparam int CC_TAG_LSB = 64;
    localparam int CC_TC_LSB = 89;
    localparam int CC_ATTR_LSB = 92;
    localparam int CC_DATA_LSB = 96;

    // requester request descriptor layout
    localparam int RQ_ADDR_LSB = 2;
    localparam int RQ_DWC_LSB = 64;
    localparam int RQ_TYPE_LSB = 75;
    localparam int RQ_TAG_LSB = 96;

    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;

    localparam logic [2:0] WIN_FIRST = 3'h0;
    localparam logic [2:0] WIN_MEM64 = 3'h1;
    localparam logic [2:0] WIN_MEM32 = 3'h2;
    localparam logic [2:0] WIN_EROM = 3'h6;

    localparam logic [10:0] DW_ONE = 11'h001;
    localparam logic [10:0] DW_NONE = 11'h000;
    localparam logic [12:0] CPL_BYTES = 13'h0004;
    localparam logic [2:0] CPL_STATUS_OK = 3'h0;
    localparam logic [2:0] NDW_CPLD = 3'h4;
    localparam logic [2:0] NDW_CPL = 3'h3;
    localparam logic [2:0] NDW_RQ = 3'h4;
    localparam logic [7:0] RQ_TAG = 8'h00;

    // 11'hEEC cut to eleven bits
    localparam logic [10:0] TRIG_IRQ_ADDR = 11'h6EC;
    localparam logic [31:0] TRIG_INTX_DATA = 32'hCCCC_DDDD;
    localparam logic [31:0] TRIG_MSI_DATA = 32'hEEEE_FFFF;
    localparam logic [31:0] TRIG_MSIX_DATA = 32'hDEAD_BEEF;
    localparam logic [10:0] TRIG_MRD_ADDR_DEF = 11'h6E8;
    localparam logic [31:0] TRIG_MRD_DATA_DEF = 32'hAAAA_BBBB;
    localparam logic [63:0] MRD_TARGET_DEF = 64'h0000_0000_0000_0000;

    typedef struct packed {
        logic has_data;
        logic [1:0] at;
        logic [6:0] lower_addr;
        logic [15:0] req_id;
        logic [7:0] tag;
        logic [2:0] tc;
        logic [2:0] attr;
        logic [31:0] data;
    } pct_cpl_t;

    typedef enum logic [2:0] {
        S_RECV = 3'b000,
        S_DECIDE = 3'b001,
        S_WRITE = 3'b010,
        S_READ = 3'b011,
        S_CPL = 3'b100
    } pct_state_t;
endpackage

// >>> pct_target.sv
`timescale 1ns/1ps

module pct_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;

    wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire empty = wr_reg == rd_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rd_reg[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) begin
            store[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
            rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
        end
    end
endmodule

module pct_tx_ser #(
    parameter int DATA_W = 256
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // descriptor in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [pct_pkg::HDR_W-1:0] in_word,
    input wire logic [2:0] in_ndw,
    // stream out
    output logic [DATA_W-1:0] tdata,
    output logic [DATA_W/32-1:0] tkeep,
    output logic tlast,
    output logic tvalid,
    input wire logic tready
);
    import pct_pkg::*;
    localparam int DPB = DATA_W / 32;

    logic busy_reg;
    logic [1:0] beat_reg;
    logic [2:0] ndw_reg;
    logic [HDR_W-1:0] word_reg;

    assign in_ready = !busy_reg;
    assign tvalid = busy_reg;
    assign tdata = DATA_W'(word_reg >> (int'(beat_reg) * DATA_W));
    assign tlast = (int'(beat_reg) + 1) * DPB >= int'(ndw_reg);

    for (genvar k = 0; k < DPB; k++) begin : g_keep
        assign tkeep[k] = (int'(beat_reg) * DPB + k) < int'(ndw_reg);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
            beat_reg <= 2'h0;
            ndw_reg <= 3'h0;
            word_reg <= '0;
        end else if (in_valid && in_ready) begin
            busy_reg <= 1'b1;
            beat_reg <= 2'h0;
            ndw_reg <= in_ndw;
            word_reg <= in_word;
        end else if (tvalid && tready) begin
            busy_reg <= !tlast;
            beat_reg <= beat_reg + 2'h1;
        end
    end
endmodule

module pct_target #(
    parameter int DATA_W = 256,
    parameter logic [10:0] TRIG_MRD_ADDR = pct_pkg::TRIG_MRD_ADDR_DEF,
    parameter logic [31:0] TRIG_MRD_DATA = pct_pkg::TRIG_MRD_DATA_DEF,
    parameter logic [63:0] MRD_TARGET_ADDR = pct_pkg::MRD_TARGET_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // completer request stream
    input wire logic [DATA_W-1:0] cq_tdata,
    input wire logic cq_tlast,
    input wire logic cq_tvalid,
    output logic cq_tready,
    // completer completion stream
    output logic [DATA_W-1:0] cc_tdata,
    output logic [DATA_W/32-1:0] cc_tkeep,
    output logic cc_tlast,
    output logic cc_tvalid,
    input wire logic cc_tready,
    // requester request stream
    output logic [DATA_W-1:0] rq_tdata,
    output logic [DATA_W/32-1:0] rq_tkeep,
    output logic rq_tlast,
    output logic rq_tvalid,
    input wire logic rq_tready,
    // interrupt requests
    output logic intx_req,
    output logic msi_req,
    output logic msix_req
);
    import pct_pkg::*;
    localparam int BEATS = HDR_W / DATA_W;

    function automatic logic [2:0] win_to_region(input logic [2:0] w);
        if (w == WIN_FIRST) begin
            return 3'b100;
        end else if (w == WIN_MEM64) begin
            return 3'b101;
        end else if (w == WIN_MEM32) begin
            return 3'b110;
        end else if (w == WIN_EROM) begin
            return 3'b111;
        end else begin
            return 3'b000;
        end
    endfunction

    function automatic logic [HDR_W-1:0] build_cc(input pct_cpl_t c);
        logic [HDR_W-1:0] w;
        w = '0;
        w[CC_LA_LSB +: 7] = c.lower_addr;
        w[CC_AT_LSB +: 2] = c.at;
        w[CC_BC_LSB +: 13] = CPL_BYTES;
        w[CC_DWC_LSB +: 11] = c.has_data ? DW_ONE : DW_NONE;
        w[CC_ST_LSB +: 3] = CPL_STATUS_OK;
        w[CC_RID_LSB +: 16] = c.req_id;
        w[CC_TAG_LSB +: 8] = c.tag;
        w[CC_TC_LSB +: 3] = c.tc;
        w[CC_ATTR_LSB +: 3] = c.attr;
        w[CC_DATA_LSB +: 32] = c.has_data ? c.data : 32'h0000_0000;
        return w;
    endfunction

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_b_reg;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b_reg <= rst_meta_reg;
        end
    end

    pct_state_t state_reg;
    pct_state_t state_next;
    logic [HDR_W-1:0] hdr_reg;
    logic [2:0] beat_reg;
    logic [31:0] rd_data_reg;
    logic [31:0] mem [0:MEM_WORDS-1];
    logic intx_reg;
    logic msi_reg;
    logic msix_reg;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    pct_cpl_t cpl_in;
    pct_cpl_t cpl_out;
    logic rq_in_ready;

    // request fields
    wire [3:0] req_type = hdr_reg[CQ_TYPE_LSB +: 4];
    wire [10:0] dw_cnt = hdr_reg[CQ_DWC_LSB +: 11];
    wire [2:0] win = hdr_reg[CQ_WIN_LSB +: 3];
    wire [2:0] region = win_to_region(win);
    wire [10:0] byte_addr = {hdr_reg[CQ_ADDR_LSB +: REGION_AW], 2'b00};
    wire [31:0] wr_data = hdr_reg[CQ_DATA_LSB +: 32];
    wire [10:0] word_addr = {region[1:0], hdr_reg[CQ_ADDR_LSB +: REGION_AW]};

    wire is_wr = (req_type == REQ_MEM_WR) || (req_type == REQ_IO_WR);
    wire is_rd = (req_type == REQ_MEM_RD) || (req_type == REQ_IO_RD);
    wire req_ok = region[2] && (dw_cnt == DW_ONE);

    wire in_write = state_reg == S_WRITE;
    wire first_win = win == WIN_FIRST;
    wire irq_hit = in_write && first_win && (byte_addr == TRIG_IRQ_ADDR);
    wire mrd_hit = in_write && first_win && (byte_addr == TRIG_MRD_ADDR)
        && (wr_data == TRIG_MRD_DATA);

    // stall while writing or busy
    // space is checked at accept so the later push never waits on the fifo
    // held low until the synced reset lets go, so no beat is lost in reset
    assign cq_tready = rst_sync_b_reg && (state_reg == S_RECV) && fifo_in_ready;
    wire cq_take = cq_tvalid && cq_tready;

    wire cpl_push = (in_write && (req_type == REQ_IO_WR)) || (state_reg == S_CPL);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_RECV: begin
                if (cq_take && cq_tlast) begin
                    state_next = S_DECIDE;
                end
            end
            S_DECIDE: begin
                if (req_ok && is_wr) begin
                    state_next = S_WRITE;
                end else if (req_ok && is_rd) begin
                    state_next = S_READ;
                end else begin
                    state_next = S_RECV;
                end
            end
            S_WRITE: state_next = S_RECV;
            S_READ: state_next = S_CPL;
            S_CPL: begin
                if (fifo_in_ready) begin
                    state_next = S_RECV;
                end
            end
            default: state_next = S_RECV;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            state_reg <= S_RECV;
        end else begin
            state_reg <= state_next;
        end
    end

    // header gathered over one to eight beats
    always_ff @(posedge clock or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            hdr_reg <= '0;
            beat_reg <= 3'h0;
        end else if (cq_take) begin
            if (int'(beat_reg) < BEATS) begin
                hdr_reg[int'(beat_reg) * DATA_W +: DATA_W] <= cq_tdata;
            end
            if (cq_tlast) begin
                beat_reg <= 3'h0;
            end else if (beat_reg != 3'h7) begin
                beat_reg <= beat_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (in_write) begin
            mem[word_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data_reg <= mem[word_addr];
    end

    always_ff @(posedge clock or negedge rst_sync_b_reg) begin
        if (!rst_sync_b_reg) begin
            intx_reg <= 1'b0;
            msi_reg <= 1'b0;
            msix_reg <= 1'b0;
        end else begin
            intx_reg <= irq_hit && (wr_data == TRIG_INTX_DATA);
            msi_reg <= irq_hit && (wr_data == TRIG_MSI_DATA);
            msix_reg <= irq_hit && (wr_data == TRIG_MSIX_DATA);
        end
    end
    assign intx_req = intx_reg;
    assign msi_req = msi_reg;
    assign msix_req = msix_reg;

    assign cpl_in = '{
        has_data: state_reg == S_CPL,
        at: hdr_reg[CQ_AT_LSB +: 2],
        lower_addr: byte_addr[6:0],
        req_id: hdr_reg[CQ_RID_LSB +: 16],
        tag: hdr_reg[CQ_TAG_LSB +: 8],
        tc: hdr_reg[CQ_TC_LSB +: 3],
        attr: hdr_reg[CQ_ATTR_LSB +: 3],
        data: rd_data_reg
    };

    pct_fifo #(
        .WIDTH($bits(pct_cpl_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_cpl_fifo (
        .clock(clock),
        .rst_b(rst_sync_b_reg),
        .in_valid(cpl_push),
        .in_ready(fifo_in_ready),
        .in_data(cpl_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(cpl_out)
    );

    pct_tx_ser #(
        .DATA_W(DATA_W)
    ) u_cc_ser (
        .clock(clock),
        .rst_b(rst_sync_b_reg),
        .in_valid(fifo_out_valid),
        .in_ready(fifo_out_ready),
        .in_word(build_cc(cpl_out)),
        .in_ndw(cpl_out.has_data ? NDW_CPLD : NDW_CPL),
        .tdata(cc_tdata),
        .tkeep(cc_tkeep),
        .tlast(cc_tlast),
        .tvalid(cc_tvalid),
        .tready(cc_tready)
    );

    // only self-started request
    // dropped if the previous one is still leaving
    logic [HDR_W-1:0] rq_word;
    always_comb begin
        rq_word = '0;
        rq_word[RQ_ADDR_LSB +: 62] = MRD_TARGET_ADDR[63:2];
        rq_word[RQ_DWC_LSB +: 11] = DW_ONE;
        rq_word[RQ_TYPE_LSB +: 4] = REQ_MEM_RD;
        rq_word[RQ_TAG_LSB +: 8] = RQ_TAG;
    end

    pct_tx_ser #(
        .DATA_W(DATA_W)
    ) u_rq_ser (
        .clock(clock),
        .rst_b(rst_sync_b_reg),
        .in_valid(mrd_hit),
        .in_ready(rq_in_ready),
        .in_word(rq_word),
        .in_ndw(NDW_RQ),
        .tdata(rq_tdata),
        .tkeep(rq_tkeep),
        .tlast(rq_tlast),
        .tvalid(rq_tvalid),
        .tready(rq_tready)
    );
endmodule

// >>> pct_target_asserts.sv
`timescale 1ns/1ps
module pct_target_asserts
    import pct_pkg::*;
#(
    parameter int DATA_W = 256
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // request stream
    input wire logic [DATA_W-1:0] cq_tdata,
    input wire logic cq_tlast,
    input wire logic cq_tvalid,
    input wire logic cq_tready,
    // completion stream
    input wire logic [DATA_W-1:0] cc_tdata,
    input wire logic [DATA_W/32-1:0] cc_tkeep,
    input wire logic cc_tlast,
    input wire logic cc_tvalid,
    input wire logic cc_tready,
    // read request stream
    input wire logic [DATA_W-1:0] rq_tdata,
    input wire logic [DATA_W/32-1:0] rq_tkeep,
    input wire logic rq_tlast,
    input wire logic rq_tvalid,
    input wire logic rq_tready,
    // interrupts
    input wire logic intx_req,
    input wire logic msi_req,
    input wire logic msix_req
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);
    localparam int KW = DATA_W / 32;
    // only the one-beat layout of the wide build is decoded here
    wire logic [127:0] d = cq_tdata[127:0];
    wire logic [31:0] pd = cq_tdata[CQ_DATA_LSB+:32];
    wire logic [2:0] win = d[CQ_WIN_LSB+:3];
    wire logic [3:0] ty = d[CQ_TYPE_LSB+:4];
    wire logic take = cq_tvalid && cq_tready && cq_tlast;
    wire logic one = d[CQ_DWC_LSB+:11] == DW_ONE;
    wire logic winok = win == WIN_FIRST || win == WIN_MEM64 || win == WIN_MEM32 || win == WIN_EROM;
    wire logic wr1 = take && one && winok && (ty == REQ_MEM_WR || ty == REQ_IO_WR);
    wire logic rd1 = take && one && winok && (ty == REQ_MEM_RD || ty == REQ_IO_RD);
    wire logic w0 = wr1 && win == WIN_FIRST;
    wire logic wi = w0 && d[CQ_ADDR_LSB+:9] == TRIG_IRQ_ADDR[10:2];
    wire logic wm = w0 && d[CQ_ADDR_LSB+:9] == TRIG_MRD_ADDR_DEF[10:2] && pd == TRIG_MRD_DATA_DEF;
    wire logic anyirq = intx_req || msi_req || msix_req;

    wr_stall_a: assert property (wr1 |=> !cq_tready [*2])
        else $error("ready not held low after a write");
    intx_cause_a: assert property (wi && pd == TRIG_INTX_DATA |-> ##[2:4] intx_req)
        else $error("legacy interrupt not requested");
    msi_cause_a: assert property (wi && pd == TRIG_MSI_DATA |-> ##[2:4] msi_req)
        else $error("msi not requested");
    msix_cause_a: assert property (wi && pd == TRIG_MSIX_DATA |-> ##[2:4] msix_req)
        else $error("msi-x not requested");
    irq_pulse_a: assert property (anyirq |=> !anyirq)
        else $error("interrupt request longer than one cycle");
    rd_answer_a: assert property (rd1 && !cc_tvalid |-> ##[4:8] cc_tvalid)
        else $error("read not answered in time");
    cpl_hold_a: assert property (cc_tvalid && !cc_tready |=> cc_tvalid && $stable(cc_tdata))
        else $error("completion changed before taken");
    cpl_fields_a: assert property (cc_tvalid |-> cc_tdata[CC_ST_LSB+:3] == CPL_STATUS_OK
        && cc_tdata[CC_BC_LSB+:13] == CPL_BYTES)
        else $error("completion status or byte count wrong");
    long_drop_a: assert property (take && !one && !cc_tvalid |=> !cc_tvalid [*6])
        else $error("long request answered");
    rq_cause_a: assert property (wm && !rq_tvalid |-> ##[2:4] rq_tvalid)
        else $error("trigger read not issued");
    rq_fields_a: assert property (rq_tvalid |-> rq_tdata[RQ_TYPE_LSB+:4] == REQ_MEM_RD
        && rq_tdata[RQ_DWC_LSB+:11] == DW_ONE)
        else $error("read request fields wrong");
    cpl_shape_a: assert property (cc_tvalid |-> cc_tlast
        && cc_tkeep == KW'({cc_tdata[CC_DWC_LSB], 3'h7}))
        else $error("completion keep or last wrong");
    rq_shape_a: assert property (rq_tvalid |-> rq_tlast && rq_tkeep == KW'(4'hF))
        else $error("read request keep or last wrong");

    cover property (intx_req);
    cover property (cc_tvalid && !cc_tready);
    cover property (rq_tvalid && rq_tready);
endmodule

bind pct_target pct_target_asserts #(.DATA_W(DATA_W)) pct_target_asserts_i (
    .clock(clock), .rst_b(rst_b), .cq_tdata(cq_tdata), .cq_tlast(cq_tlast),
    .cq_tvalid(cq_tvalid), .cq_tready(cq_tready), .cc_tdata(cc_tdata), .cc_tkeep(cc_tkeep),
    .cc_tlast(cc_tlast), .cc_tvalid(cc_tvalid), .cc_tready(cc_tready), .rq_tdata(rq_tdata),
    .rq_tkeep(rq_tkeep), .rq_tlast(rq_tlast), .rq_tvalid(rq_tvalid), .rq_tready(rq_tready),
    .intx_req(intx_req), .msi_req(msi_req), .msix_req(msix_req));

// >>> pct_host_model.sv
`timescale 1ns/1ps
module pct_host_model (
    // clock
    input wire logic clock,
    // requests toward the block
    output logic [255:0] cq_tdata,
    output logic cq_tlast,
    output logic cq_tvalid,
    input wire logic cq_tready,
    // completions and read requests back
    input wire logic [255:0] cc_tdata,
    input wire logic cc_tvalid,
    output logic cc_tready,
    input wire logic [255:0] rq_tdata,
    input wire logic rq_tvalid,
    output logic rq_tready
);
    logic [127:0] cpl_q[$];
    logic [127:0] rq_last = '0;
    int rq_n = 0;
    logic cc_go = 1'b1;
    logic slow = 1'b0;
    logic ph = 1'b0;
    logic hit = 1'b0;
    initial begin
        cq_tdata = '0;
        cq_tlast = 1'b0;
        cq_tvalid = 1'b0;
    end
    // slow mode takes a completion beat only every other cycle
    assign cc_tready = cc_go && (!slow || ph);
    assign rq_tready = 1'b1;
    always @(posedge clock) begin
        ph <= !ph;
        hit <= cq_tvalid && cq_tready;
        if (cc_tvalid && cc_tready) begin
            cpl_q.push_back(cc_tdata[127:0]);
        end
        if (rq_tvalid && rq_tready) begin
            rq_n <= rq_n + 1;
            rq_last <= rq_tdata[127:0];
        end
    end
    task automatic send(input logic [127:0] d, input logic [31:0] p);
        @(posedge clock);
        #1;
        cq_tdata = {96'h0, p, d};
        cq_tlast = 1'b1;
        cq_tvalid = 1'b1;
        do begin
            @(posedge clock);
            #1;
        end while (!hit);
        // inverted so a stale beat never looks like a fresh one
        cq_tdata = ~cq_tdata;
        cq_tvalid = 1'b0;
        cq_tlast = 1'b0;
    endtask
endmodule

// >>> test_pct_target.sv
`timescale 1ns/1ps
module test_pct_target;
    import pct_pkg::*;
    logic clock;
    logic rst_b;
    logic [255:0] cq_tdata, cc_tdata, rq_tdata;
    logic [7:0] cc_tkeep, rq_tkeep;
    logic cq_tlast, cq_tvalid, cq_tready, cc_tlast, cc_tvalid, cc_tready;
    logic rq_tlast, rq_tvalid, rq_tready, intx_req, msi_req, msix_req;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int irq_n[3] = '{0, 0, 0};
    int i;

    pct_host_model pct_host_model_i (.clock(clock), .cq_tdata(cq_tdata), .cq_tlast(cq_tlast),
        .cq_tvalid(cq_tvalid), .cq_tready(cq_tready), .cc_tdata(cc_tdata), .cc_tvalid(cc_tvalid),
        .cc_tready(cc_tready), .rq_tdata(rq_tdata), .rq_tvalid(rq_tvalid), .rq_tready(rq_tready));
    pct_target #(.DATA_W(256)) pct_target_i (.clock(clock), .rst_b(rst_b),
        .cq_tdata(cq_tdata), .cq_tlast(cq_tlast), .cq_tvalid(cq_tvalid), .cq_tready(cq_tready),
        .cc_tdata(cc_tdata), .cc_tkeep(cc_tkeep), .cc_tlast(cc_tlast), .cc_tvalid(cc_tvalid),
        .cc_tready(cc_tready), .rq_tdata(rq_tdata), .rq_tkeep(rq_tkeep), .rq_tlast(rq_tlast),
        .rq_tvalid(rq_tvalid), .rq_tready(rq_tready), .intx_req(intx_req), .msi_req(msi_req),
        .msix_req(msix_req));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        irq_n[0] <= irq_n[0] + intx_req;
        irq_n[1] <= irq_n[1] + msi_req;
        irq_n[2] <= irq_n[2] + msix_req;
        if (cycles == 30000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [127:0] req(input logic [3:0] t, input logic [2:0] w,
        input logic [31:0] a, input logic [10:0] n, input logic [7:0] tg);
        req = '0;
        req[CQ_ADDR_LSB+:30] = a[31:2];
        req[CQ_DWC_LSB+:11] = n;
        req[CQ_TYPE_LSB+:4] = t;
        req[CQ_RID_LSB+:16] = 16'hA5C3;
        req[CQ_TAG_LSB+:8] = tg;
        req[CQ_WIN_LSB+:3] = w;
        req[CQ_TC_LSB+:3] = 3'h5;
        req[CQ_ATTR_LSB+:3] = 3'h2;
    endfunction
    // reserved fields are masked, only echoed, fixed and read data fields judged
    task automatic cpl(input logic [31:0] a, input logic [7:0] tg, input logic hd,
        input logic [31:0] dat);
        logic [127:0] e;
        logic [127:0] m;
        int n;
        e = '0;
        e[CC_LA_LSB+:7] = {a[6:2], 2'b00};
        e[CC_BC_LSB+:13] = CPL_BYTES;
        e[CC_DWC_LSB+:11] = hd ? DW_ONE : DW_NONE;
        e[CC_ST_LSB+:3] = CPL_STATUS_OK;
        e[CC_RID_LSB+:16] = 16'hA5C3;
        e[CC_TAG_LSB+:8] = tg;
        e[CC_TC_LSB+:3] = 3'h5;
        e[CC_ATTR_LSB+:3] = 3'h2;
        e[CC_DATA_LSB+:32] = hd ? dat : 32'h0;
        m = {hd ? 32'hFFFF_FFFF : 32'h0, 96'h7E0000FF_FFFF3FFF_1FFF037F};
        n = 0;
        while (pct_host_model_i.cpl_q.size() == 0 && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (n == 200) chk(128'h0, e); // answer missing
        else chk(pct_host_model_i.cpl_q.pop_front() & m, e); // echoed fields
    endtask
    task automatic wr(input logic [2:0] w, input logic [31:0] a, input logic [31:0] d);
        pct_host_model_i.send(req(REQ_MEM_WR, w, a, DW_ONE, 8'h00), d);
    endtask
    task automatic rd(input logic [2:0] w, input logic [31:0] a, input logic [7:0] tg,
        input logic [31:0] e);
        pct_host_model_i.send(req(REQ_MEM_RD, w, a, DW_ONE, tg), 32'h0);
        cpl(a, tg, 1'b1, e); // one data dword
    endtask

    task automatic t_regions;
        logic [2:0] wl[4] = '{WIN_FIRST, WIN_MEM64, WIN_MEM32, WIN_EROM};
        for (i = 0; i < 4; i++) wr(wl[i], 32'h7FC, 32'h5A00_0000 + i);
        for (i = 0; i < 4; i++) rd(wl[i], 32'h7FC, i[7:0], 32'h5A00_0000 + i);
    endtask
    task automatic t_wrap_io;
        wr(WIN_MEM32, 32'h804, 32'hBEE5_0804);
        rd(WIN_MEM32, 32'h4, 8'h50, 32'hBEE5_0804); // wrapped word
        pct_host_model_i.send(req(REQ_IO_WR, WIN_MEM32, 32'h10, DW_ONE, 8'h33), 32'h1234_5678);
        cpl(32'h10, 8'h33, 1'b0, 32'h0); // no data
        pct_host_model_i.send(req(REQ_IO_RD, WIN_MEM32, 32'h10, DW_ONE, 8'h34), 32'h0);
        cpl(32'h10, 8'h34, 1'b1, 32'h1234_5678); // io read
    endtask
    task automatic t_refuse;
        pct_host_model_i.send(req(REQ_MEM_RD, WIN_MEM64, 32'h7FC, 11'h002, 8'h40), 32'h0);
        pct_host_model_i.send(req(REQ_MEM_RD, 3'h3, 32'h7FC, DW_ONE, 8'h41), 32'h0);
        repeat (20) @(posedge clock);
        chk(pct_host_model_i.cpl_q.size(), 0); // nothing answered
        rd(WIN_MEM64, 32'h7FC, 8'h42, 32'h5A00_0001); // still serving
    endtask
    task automatic t_irq;
        logic [31:0] dl[3] = '{TRIG_INTX_DATA, TRIG_MSI_DATA, TRIG_MSIX_DATA};
        for (i = 0; i < 3; i++) begin
            wr(WIN_FIRST, {21'h0, TRIG_IRQ_ADDR}, dl[i]);
            repeat (8) @(posedge clock);
            chk(irq_n[i], 1); // one pulse
            chk(irq_n[0] + irq_n[1] + irq_n[2], i + 1); // no other
        end
        wr(WIN_FIRST, {21'h0, TRIG_IRQ_ADDR}, 32'h0);
        wr(WIN_MEM64, {21'h0, TRIG_IRQ_ADDR}, TRIG_INTX_DATA);
        repeat (8) @(posedge clock);
        chk(irq_n[0] + irq_n[1] + irq_n[2], 3); // no false trigger
        rd(WIN_MEM64, {21'h0, TRIG_IRQ_ADDR}, 8'h60, TRIG_INTX_DATA); // stored
    endtask
    task automatic t_mrd;
        wr(WIN_FIRST, {21'h0, TRIG_MRD_ADDR_DEF}, 32'h0);
        wr(WIN_FIRST, {21'h0, TRIG_MRD_ADDR_DEF}, TRIG_MRD_DATA_DEF);
        repeat (8) @(posedge clock);
        chk(pct_host_model_i.rq_n, 1); // one request
        chk({pct_host_model_i.rq_last[RQ_TYPE_LSB+:4], pct_host_model_i.rq_last[RQ_DWC_LSB+:11],
            pct_host_model_i.rq_last[RQ_ADDR_LSB+:62]},
            {REQ_MEM_RD, DW_ONE, MRD_TARGET_DEF[63:2]}); // request fields
    endtask
    task automatic t_fifo;
        int n;
        for (i = 0; i < 24; i++) wr(WIN_MEM64, i * 4, 32'hF1F0_0000 + i);
        pct_host_model_i.cc_go = 1'b0;
        for (n = 0; n < 24; n++) begin
            repeat (8) @(posedge clock);
            #1;
            if (cq_tready !== 1'b1) break;
            pct_host_model_i.send(req(REQ_MEM_RD, WIN_MEM64, n * 4, DW_ONE, n[7:0]), 32'h0);
        end
        chk(n >= FIFO_DEPTH && n < 24, 1'b1); // back-pressure
        pct_host_model_i.slow = 1'b1;
        pct_host_model_i.cc_go = 1'b1;
        for (i = 0; i < n; i++) cpl(i * 4, i[7:0], 1'b1, 32'hF1F0_0000 + i); // in order
        chk(pct_host_model_i.cpl_q.size(), 0); // no extra
    endtask

    initial begin
        rst_b = 1'b0;
        repeat (12) @(posedge clock);
        chk({cq_tready, cc_tvalid, rq_tvalid}, 3'h0); // quiet in reset
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clock);
        t_regions();
        t_wrap_io();
        t_refuse();
        t_irq();
        t_mrd();
        t_fifo();
        stop_test();
    end
endmodule
